// ---- rtl/acc_pkg.sv ----
// Package for the analog comparator control block: map, fields, types
package acc_pkg;
    // Register byte addresses (printed offset plus own choices)
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h30;
    localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h34;
    localparam logic [7:0] ADDR_DIN_DISABLE = 8'h38;
    localparam logic [7:0] ADDR_CONV_CTRL_A = 8'h3C;
    localparam logic [7:0] ADDR_CONV_MUX    = 8'h40;
    // Field positions in the control/status, conversion and channel mux registers
    localparam int BIT_OFF      = 7;
    localparam int BIT_BANDGAP  = 6;
    localparam int BIT_RESULT   = 5;
    localparam int BIT_FLAG     = 4;
    localparam int BIT_IRQ_EN   = 3;
    localparam int BIT_CAPTURE  = 2;
    localparam int BIT_MODE_HI  = 1;
    localparam int BIT_MUX_EN   = 6;
    localparam int BIT_CONV_EN  = 7;
    localparam int BIT_CH_HI    = 2;
    localparam int NUM_CHANNELS = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Interrupt event modes
    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'h0,
        MODE_RESERVED = 2'h1,
        MODE_FALL     = 2'h2,
        MODE_RISE     = 2'h3
    } acc_mode_type;
    // Analog routing selects handed to the comparator macro
    typedef struct packed {
        logic       power_off;
        logic       pos_bandgap;
        logic       neg_from_mux;
        logic [2:0] channel;
    } acc_route_type;
endpackage

// ---- rtl/acc_ctrl.sv ----
// Analog comparator control: routing, synchroniser, events, Wishbone slave
`timescale 1ns/1ps
module acc_ctrl (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Analog macro side
    input  wire logic                  cmp_raw_i,
    output acc_pkg::acc_route_type     route_o,
    // Pins and system
    input  wire logic [1:0]            pin_digital_i,
    output logic      [1:0]            pin_digital_o,
    output logic      [1:0]            din_buf_off_o,
    input  wire logic                  global_irq_en_i,
    input  wire logic                  irq_vector_ack_i,
    output logic                       irq_o,
    output logic                       capture_o
);
    logic [7:0]  csr_q, csr_d;
    logic [7:0]  convb_q, convb_d, din_q, din_d, conva_q, conva_d;
    logic [7:0]  cmux_q, cmux_d;
    logic        sync1_q, sync2_q, prev_q;
    logic        flag_q, flag_d;
    logic [31:0] rdat_d;
    logic        ack_d, irq_d, cap_d;
    logic [1:0]  pin_d;
    acc_pkg::acc_route_type route_d;
    logic        wr, event_hit;
    logic        sw_clear;
    acc_pkg::acc_mode_type mode;

    // Shared clock and reset of every assertion below
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                  && wb_sel_i[0];
    assign mode = acc_pkg::acc_mode_type'(csr_q[acc_pkg::BIT_MODE_HI:0]);
    // Mode decode drives the edge select
    // Software clear of the flag, watched by the assertions
    assign sw_clear = wr && (wb_adr_i == acc_pkg::ADDR_CTRL_STATUS)
                      && wb_dat_i[acc_pkg::BIT_FLAG];

    // One input gate per comparator pin
    for (genvar b = 0; b < $bits(pin_d); b++) begin : g_pin
        assign pin_d[b] = pin_digital_i[b] && !din_q[b];
    end

    // Edge found on synchronised samples only
    always_comb begin
        case (mode)
            acc_pkg::MODE_TOGGLE: event_hit = sync2_q != prev_q;
            acc_pkg::MODE_FALL:   event_hit = prev_q && !sync2_q;
            acc_pkg::MODE_RISE:   event_hit = !prev_q && sync2_q;
            default:              event_hit = 1'b0;
        endcase
    end

    always_comb begin
        csr_d   = csr_q;
        convb_d = convb_q;
        din_d   = din_q;
        conva_d = conva_q;
        cmux_d  = cmux_q;
        flag_d  = flag_q;
        if (irq_vector_ack_i) begin
            flag_d = 1'b0;
        end
        if (wr) begin
            case (wb_adr_i)
                acc_pkg::ADDR_CTRL_STATUS: begin
                    csr_d = wb_dat_i[7:0];
                    if (wb_dat_i[acc_pkg::BIT_FLAG]) begin
                        flag_d = 1'b0;
                    end
                end
                acc_pkg::ADDR_CONV_CTRL_B: convb_d = wb_dat_i[7:0];
                acc_pkg::ADDR_DIN_DISABLE: din_d   = wb_dat_i[7:0];
                acc_pkg::ADDR_CONV_CTRL_A: conva_d = wb_dat_i[7:0];
                acc_pkg::ADDR_CONV_MUX:    cmux_d  = wb_dat_i[7:0];
                default: ;
            endcase
        end
        // Set beats a same-cycle clear
        if (event_hit) begin
            flag_d = 1'b1;
        end
    end

    always_comb begin
        ack_d  = wb_cyc_i && wb_stb_i && !wb_ack_o;
        rdat_d = 32'h0000_0000;
        case (wb_adr_i)
            acc_pkg::ADDR_CTRL_STATUS: begin
                rdat_d[7:0] = csr_q;
                rdat_d[acc_pkg::BIT_RESULT] = sync2_q;
                rdat_d[acc_pkg::BIT_FLAG]   = flag_q;
            end
            acc_pkg::ADDR_CONV_CTRL_B: rdat_d[7:0] = convb_q;
            acc_pkg::ADDR_DIN_DISABLE: rdat_d[7:0] = din_q;
            acc_pkg::ADDR_CONV_CTRL_A: rdat_d[7:0] = conva_q;
            acc_pkg::ADDR_CONV_MUX:    rdat_d[7:0] = cmux_q;
            default:                   rdat_d = 32'h0000_0000;
        endcase
        irq_d = flag_q && csr_q[acc_pkg::BIT_IRQ_EN]
                && global_irq_en_i;
        cap_d = csr_q[acc_pkg::BIT_CAPTURE] && sync2_q;
        route_d.power_off   = csr_q[acc_pkg::BIT_OFF];
        route_d.pos_bandgap = csr_q[acc_pkg::BIT_BANDGAP];
        route_d.neg_from_mux = convb_q[acc_pkg::BIT_MUX_EN]
                && !conva_q[acc_pkg::BIT_CONV_EN];
        route_d.channel     = cmux_q[acc_pkg::BIT_CH_HI:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_q    <= acc_pkg::RESET_BYTE;
            convb_q  <= acc_pkg::RESET_BYTE;
            din_q    <= acc_pkg::RESET_BYTE;
            conva_q  <= acc_pkg::RESET_BYTE;
            cmux_q   <= acc_pkg::RESET_BYTE;
            flag_q   <= 1'b0;
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            prev_q   <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o    <= 1'b0;
            capture_o <= 1'b0;
            pin_digital_o <= 2'h0;
            din_buf_off_o <= 2'h0;
            route_o  <= '0;
        end else begin
            csr_q    <= csr_d;
            convb_q  <= convb_d;
            din_q    <= din_d;
            conva_q  <= conva_d;
            cmux_q   <= cmux_d;
            flag_q   <= flag_d;
            // is the macro's: cmp_raw_i high when positive > negative
            sync1_q  <= cmp_raw_i;
            sync2_q  <= sync1_q;
            prev_q   <= sync2_q;
            wb_ack_o <= ack_d;
            wb_dat_o <= rdat_d;
            irq_o    <= irq_d;
            capture_o <= cap_d;
            pin_digital_o <= pin_d;
            din_buf_off_o <= din_q[1:0];
            route_o  <= route_d;
        end
    end

    // Assertions: clock and reset come from the defaults above
    // Flag set, priority and clear paths
    AST_FLAG_SET: assert property (event_hit |=> flag_q)
        else $error("flag not set after event");

    AST_SET_WINS: assert property (
        event_hit && (sw_clear || irq_vector_ack_i) |=> flag_q)
        else $error("clear won over a same-cycle event");

    AST_RESERVED: assert property (
        (mode == acc_pkg::MODE_RESERVED) && !flag_q
        && !irq_vector_ack_i |=> !flag_q)
        else $error("reserved mode set flag");

    AST_VEC_CLEAR: assert property (
        irq_vector_ack_i && !event_hit |=> !flag_q)
        else $error("vector did not clear flag");

    AST_SW_CLEAR: assert property (
        sw_clear && !event_hit |=> !flag_q)
        else $error("write of one did not clear flag");

    AST_FLAG_HOLD: assert property (
        !event_hit && !sw_clear && !irq_vector_ack_i
        |=> flag_q == $past(flag_q))
        else $error("flag moved with no event or clear");

    // Interrupt request gating
    AST_IRQ_GATE: assert property (
        irq_o |-> $past(flag_q) && $past(global_irq_en_i))
        else $error("irq without flag and global enable");

    AST_IRQ_ENABLE: assert property (
        irq_o |-> $past(csr_q[acc_pkg::BIT_IRQ_EN]))
        else $error("irq while local enable clear");

    AST_IRQ_SET: assert property (
        flag_q && csr_q[acc_pkg::BIT_IRQ_EN] && global_irq_en_i
        |=> irq_o)
        else $error("irq missing with flag and both enables");

    // Synchroniser and edge modes
    AST_SYNC_LAT: assert property (
        $stable(cmp_raw_i)[*3] |-> sync2_q == cmp_raw_i)
        else $error("result not synchronised in two cycles");

    AST_RESULT_RD: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o
        && (wb_adr_i == acc_pkg::ADDR_CTRL_STATUS)
        |=> wb_dat_o[acc_pkg::BIT_RESULT] == $past(sync2_q))
        else $error("read result differs from synchronised value");

    AST_RISE: assert property (
        mode == acc_pkg::MODE_RISE && $rose(sync2_q) |=> flag_q)
        else $error("rising edge missed");

    AST_FALL: assert property (
        mode == acc_pkg::MODE_FALL && $fell(sync2_q) |=> flag_q)
        else $error("falling edge missed");

    AST_TOGGLE: assert property (
        mode == acc_pkg::MODE_TOGGLE && $changed(sync2_q) |=> flag_q)
        else $error("toggle missed");

    // Capture route
    AST_CAPTURE: assert property (
        !csr_q[acc_pkg::BIT_CAPTURE] |=> !capture_o)
        else $error("capture routed while disabled");

    AST_CAP_ON: assert property (
        csr_q[acc_pkg::BIT_CAPTURE] |=> capture_o == $past(sync2_q))
        else $error("capture does not follow result");

    // Analog routing
    AST_NEG_MUX: assert property (
        conva_q[acc_pkg::BIT_CONV_EN] |=> !route_o.neg_from_mux)
        else $error("mux used while converter on");

    AST_MUX_SEL: assert property (
        convb_q[acc_pkg::BIT_MUX_EN] && !conva_q[acc_pkg::BIT_CONV_EN]
        |=> route_o.neg_from_mux)
        else $error("mux not used while enabled and converter off");

    AST_MUX_OFF: assert property (
        !convb_q[acc_pkg::BIT_MUX_EN] |=> !route_o.neg_from_mux)
        else $error("mux used while mux enable clear");

    AST_CHANNEL: assert property (
        1'b1 |=> route_o.channel == $past(cmux_q[acc_pkg::BIT_CH_HI:0]))
        else $error("channel select not passed on");

    AST_POWER: assert property (
        1'b1 |=> route_o.power_off == $past(csr_q[acc_pkg::BIT_OFF]))
        else $error("power off not passed on");

    AST_BANDGAP: assert property (
        1'b1 |=> route_o.pos_bandgap == $past(csr_q[acc_pkg::BIT_BANDGAP]))
        else $error("bandgap select not passed on");

    // Pins and buffers
    AST_PIN_OFF: assert property (
        din_q[0] |=> !pin_digital_o[0])
        else $error("disabled pin read nonzero");

    AST_PIN_ON: assert property (
        !din_q[1] |=> pin_digital_o[1] == $past(pin_digital_i[1]))
        else $error("enabled pin not passed on");

    AST_BUF_OFF: assert property (
        1'b1 |=> din_buf_off_o == $past(din_q[1:0]))
        else $error("buffer disable not passed on");

    // Bus handshake: one ack per request, always one cycle late
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_ACK_REQ: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    // Main scenarios
    COV_TOGGLE: cover property (@(posedge clk_i)
        mode == acc_pkg::MODE_TOGGLE && event_hit);
    COV_FALL: cover property (@(posedge clk_i)
        mode == acc_pkg::MODE_FALL && event_hit);
    COV_RISE: cover property (@(posedge clk_i)
        mode == acc_pkg::MODE_RISE && event_hit);
    COV_IRQ: cover property (@(posedge clk_i) $rose(irq_o));
    COV_SW_CLEAR: cover property (@(posedge clk_i) flag_q ##1 !flag_q);
endmodule

// ---- tb/acc_analog_model.sv ----
// Behavioural analog front end: pins, channels, bandgap, comparator
`timescale 1ns/1ps
module acc_analog_model #(
    parameter int BANDGAP_MV = 1000
) (
    // Routing from the block
    input  acc_pkg::acc_route_type route_i,
    // Voltages in millivolts
    input  int                     pos_mv_i,
    input  int                     neg_mv_i,
    input  int                     ch_mv_i [8],
    // Raw comparator output
    output logic                   cmp_o
);
    int p;
    int n;
    always_comb begin
        p = route_i.pos_bandgap ? BANDGAP_MV : pos_mv_i;
        n = route_i.neg_from_mux ? ch_mv_i[route_i.channel]
                                 : neg_mv_i;
        // Powered-down comparator gives a steady low
        cmp_o = !route_i.power_off && (p > n);
    end
endmodule

// ---- tb/acc_ctrl_tb.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module acc_ctrl_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic gie = 1'b0;
    logic vack = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] rd;
    logic [7:0] ex;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack, cmp, irq, cap;
    logic [1:0] pin = 2'h3;
    logic [1:0] pin_o, boff;
    acc_pkg::acc_route_type route;
    int pos = 100;
    int neg = 500;
    int ch[8] = '{5: 900, default: 0};
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    always #12.5 clk_i = ~clk_i;
    acc_ctrl acc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cmp_raw_i(cmp),
        .route_o(route), .pin_digital_i(pin), .pin_digital_o(pin_o),
        .din_buf_off_o(boff), .global_irq_en_i(gie),
        .irq_vector_ack_i(vack), .irq_o(irq), .capture_o(cap));
    acc_analog_model acc_analog_model_i (.route_i(route), .pos_mv_i(pos),
        .neg_mv_i(neg), .ch_mv_i(ch), .cmp_o(cmp));
    task automatic complete_run;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Request held until ack seen high; read data taken with it
    task automatic wb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20)
            fails++;
        rd = dat_o[7:0];
        req <= 1'b0;
    endtask
    // Sync plus edge detect plus flag need a few cycles
    task automatic set_pos(input int v);
        @(posedge clk_i);
        pos <= v;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run;
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'h30, 8'h00);
        `CHK(rd, 8'h00)
        wb(0, 8'h44, 8'h00);
        `CHK(rd, 8'h00)
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            wb(1, 8'h30, 8'h10 | m[7:0]);
            set_pos(700);
            wb(0, 8'h30, 8'h00);
            ex = {3'b001, m == 0 || m == 3, 2'b00, m[1:0]};
            `CHK(rd, ex)
            wb(1, 8'h30, 8'h10 | m[7:0]);
            set_pos(100);
            wb(0, 8'h30, 8'h00);
            ex = {3'b000, m == 0 || m == 2, 2'b00, m[1:0]};
            `CHK(rd, ex)
        end
        $display("test modes done");
        wb(1, 8'h30, 8'h18);
        @(posedge clk_i);
        gie <= 1'b1;
        set_pos(700);
        `CHK(irq, 1'b1)
        @(posedge clk_i);
        gie <= 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK(irq, 1'b0)
        @(posedge clk_i);
        gie <= 1'b1;
        vack <= 1'b1;
        @(posedge clk_i);
        vack <= 1'b0;
        wb(0, 8'h30, 8'h00);
        `CHK(rd, 8'h28)
        `CHK(irq, 1'b0)
        $display("test interrupt done");
        wb(1, 8'h30, 8'h04);
        @(negedge clk_i);
        `CHK(cap, 1'b1)
        wb(1, 8'h40, 8'h05);
        wb(1, 8'h34, 8'h40);
        repeat (4) @(posedge clk_i);
        wb(0, 8'h30, 8'h00);
        `CHK(rd[5], 1'b0)
        `CHK(route.channel, 3'h5)
        wb(1, 8'h3C, 8'h80);
        repeat (4) @(posedge clk_i);
        wb(0, 8'h30, 8'h00);
        `CHK(rd[5], 1'b1)
        $display("test mux done");
        wb(1, 8'h30, 8'hC0);
        repeat (4) @(posedge clk_i);
        wb(0, 8'h30, 8'h00);
        `CHK(rd[7:5], 3'h6)
        `CHK({route.power_off, route.pos_bandgap}, 2'h3)
        wb(1, 8'h38, 8'h01);
        @(negedge clk_i);
        `CHK({boff, pin_o}, 4'h6)
        // Write with lane 0 deselected must be ignored
        @(posedge clk_i);
        sel <= 4'hE;
        wb(1, 8'h38, 8'h03);
        sel <= 4'hF;
        wb(0, 8'h38, 8'h00);
        `CHK(rd, 8'h01)
        $display("test power and pins done");
        complete_run;
    end
endmodule
